// ---- ccrs_pkg.sv ----
// Package of constants and types for the core register state block
package ccrs_pkg;

	localparam int ACC_W = 8;
	localparam int PTR_W = 14;
	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;

	// Reset values of the architectural state
	localparam logic [ACC_W-1:0] ACC_RESET = 8'h00;
	localparam logic [PTR_W-1:0] START_ADDR = 14'h3ffd;
	localparam logic ZERO_RESET = 1'h0;
	localparam logic CARRY_RESET = 1'h0;
	localparam logic [7:0] INDEX_RESET = 8'h00;
	localparam logic [7:0] PAGE_RESET = 8'h00;

	// Memory-mapped register indices, byte address is four times the index
	localparam logic [AXI_AW-1:0] IDX_WINDOW = 8'h0e;
	localparam logic [AXI_AW-1:0] IDX_INDEX = 8'h0f;
	localparam logic [AXI_AW-1:0] IDX_PAGE = 8'h1f;
	localparam logic [AXI_AW-1:0] IDX_CORE_STATE = 8'h20;

	// Core address map features
	localparam logic [PTR_W-1:0] WINDOW_ADDR = 14'h000e;
	localparam logic [PTR_W-1:0] PAGE_WIN_LO = 14'h00c0;
	localparam logic [PTR_W-1:0] PAGE_WIN_HI = 14'h00ff;
	localparam int PAGE_OFS_W = 6;
	localparam logic [PTR_W-1:0] MEM_TOP_DEFAULT = 14'h3fff;

	// Bit positions and constants used by the ALU
	localparam int MSB = ACC_W - 1;
	localparam logic [ACC_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [ACC_W-1:0] ZERO_BYTE = 8'h00;
	localparam int FLAG_Z = 1;
	localparam int FLAG_C = 0;

	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Operations issued by the instruction decoder
	typedef enum logic [4:0] {
		OP_NONE, OP_LOAD, OP_STORE, OP_MOVE, OP_ADD, OP_SUB, OP_CMP,
		OP_AND, OP_OR, OP_EOR, OP_INC, OP_DEC, OP_CLR, OP_LSL, OP_LSR,
		OP_ROL, OP_ROR, OP_JUMP, OP_BRANCH, OP_JUMP_SUB, OP_RETURN,
		OP_SWAP_HIGH, OP_SWAP_LOW, OP_SET_CARRY, OP_CLEAR_CARRY,
		OP_BRANCH_BIT_SET, OP_BRANCH_BIT_CLEAR, OP_COUNT
	} ccrs_op_t;

endpackage

// ---- ccrs_core.sv ----
// Architectural register state, address generation and memory-mapped registers of the core
//
// Our own choice: the AXI4-Lite register port.
module ccrs_core
	import ccrs_pkg::*;
#(
	parameter logic [PTR_W-1:0] MEM_TOP = MEM_TOP_DEFAULT,
	parameter int DP_DEPTH = 256
)
(
	input wire logic clock,
	input wire logic rst,
	// Operation port from the instruction decoder
	input wire logic opValid,
	input wire logic [4:0] opCode,
	input wire logic [ACC_W-1:0] opOperand,
	input wire logic [PTR_W-1:0] opTarget,
	input wire logic opBit,
	input wire logic fetchStrobe,
	// Core address generation
	input wire logic xlatValid,
	input wire logic [PTR_W-1:0] xlatAddr,
	output logic [PTR_W-1:0] physAddr,
	output logic physValid,
	output logic coreResetReq,
	// Architectural state
	output logic [ACC_W-1:0] accumulator,
	output logic [PTR_W-1:0] instructionPointer,
	output logic [PTR_W-1:0] shadowReturnCounter,
	// Debug access to the condition flags
	input wire logic dbgFlagWe,
	input wire logic [1:0] dbgFlagWdata,
	output logic [1:0] dbgFlags,
	// AXI4-Lite slave
	input wire logic [AXI_AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [AXI_DW-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AXI_AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [AXI_DW-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	logic [ACC_W-1:0] acc_q, acc_d;
	logic [PTR_W-1:0] ip_q, ip_d;
	logic [PTR_W-1:0] ret_q, ret_d;
	logic zero_q, zero_d;
	logic carry_q, carry_d;
	logic [7:0] index_q;
	logic [7:0] page_q;
	logic [7:0] dpRam [DP_DEPTH];
	logic illegalOp, illegalAddr, illegalHit;
	logic [PTR_W-1:0] xlatPhys;
	ccrs_op_t op;

	//////////////////////////////////////////////////////////////////////////////
	// Decode and illegal detection

	// Codes past the last defined operation are illegal
	assign illegalOp = opValid && (opCode >= OP_COUNT);
	// A code left on the port after the strobe drops must not run again
	assign op = (!opValid || illegalOp) ? OP_NONE : ccrs_op_t'(opCode);

	// Address translation for the window and the paged region
	always_comb
	begin
		xlatPhys = xlatAddr;
		if (xlatAddr == WINDOW_ADDR)
			xlatPhys = {6'h00, index_q};
		else if (xlatAddr >= PAGE_WIN_LO && xlatAddr <= PAGE_WIN_HI)
			xlatPhys = {page_q, xlatAddr[PAGE_OFS_W-1:0]};
	end

	assign illegalAddr = xlatValid && (xlatPhys > MEM_TOP);
	assign illegalHit = illegalOp || illegalAddr;

	// Translated address is registered so the memory sees a clean bus
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			physAddr <= START_ADDR;
			physValid <= 1'b0;
		end
		else
		begin
			physAddr <= xlatPhys;
			physValid <= xlatValid && !illegalAddr;
		end
	end

	// One-cycle pulse asking the system to reset; local state reloads at once
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			coreResetReq <= 1'b0;
		else
			coreResetReq <= illegalHit;
	end

	//////////////////////////////////////////////////////////////////////////////
	// ALU and flow control

	// Computes next accumulator, flags, pointer and return counter
	always_comb
	begin
		logic [ACC_W:0] sum;
		sum = '0;
		acc_d = acc_q;
		zero_d = zero_q;
		carry_d = carry_q;
		ret_d = ret_q;
		ip_d = fetchStrobe ? ip_q + 14'h0001 : ip_q;
		case (op)
			OP_LOAD:
			begin
				acc_d = opOperand;
				zero_d = (opOperand == ZERO_BYTE);
			end
			OP_STORE:
				zero_d = (acc_q == ZERO_BYTE);
			OP_MOVE:
				zero_d = (opOperand == ZERO_BYTE);
			OP_ADD:
			begin
				sum = {1'b0, acc_q} + {1'b0, opOperand};
				acc_d = sum[MSB:0];
				// Unsigned overflow from the top bits of operands and result
				carry_d = (acc_q[MSB] && opOperand[MSB])
					|| ((acc_q[MSB] || opOperand[MSB]) && !sum[MSB]);
				zero_d = (sum[MSB:0] == ZERO_BYTE);
			end
			OP_SUB, OP_CMP:
			begin
				sum = {1'b0, acc_q} - {1'b0, opOperand};
				if (op == OP_SUB)
					acc_d = sum[MSB:0];
				carry_d = (opOperand > acc_q);
				zero_d = (sum[MSB:0] == ZERO_BYTE);
			end
			OP_AND, OP_OR, OP_EOR:
			begin
				acc_d = (op == OP_AND) ? (acc_q & opOperand)
					: (op == OP_OR) ? (acc_q | opOperand) : (acc_q ^ opOperand);
				zero_d = (acc_d == ZERO_BYTE);
			end
			OP_INC, OP_DEC:
			begin
				acc_d = (op == OP_INC) ? acc_q + ONE_BYTE : acc_q - ONE_BYTE;
				zero_d = (acc_d == ZERO_BYTE);
			end
			OP_CLR:
			begin
				acc_d = ZERO_BYTE;
				zero_d = 1'b1;
			end
			// Nine-bit shifts through carry
			OP_LSL, OP_ROL:
			begin
				acc_d = {acc_q[MSB-1:0], (op == OP_ROL) ? carry_q : 1'b0};
				carry_d = acc_q[MSB];
				zero_d = (acc_d == ZERO_BYTE);
			end
			OP_LSR, OP_ROR:
			begin
				acc_d = {(op == OP_ROR) ? carry_q : 1'b0, acc_q[MSB:1]};
				carry_d = acc_q[0];
				zero_d = (acc_d == ZERO_BYTE);
			end
			OP_JUMP, OP_BRANCH:
				ip_d = opTarget;
			OP_JUMP_SUB:
			begin
				// Return address is the sequential next location
				ret_d = fetchStrobe ? ip_q + 14'h0001 : ip_q;
				ip_d = opTarget;
			end
			OP_RETURN:
				ip_d = ret_q;
			OP_SWAP_HIGH:
			begin
				acc_d = {2'b00, ret_q[PTR_W-1:ACC_W]};
				ret_d = {acc_q[PTR_W-ACC_W-1:0], ret_q[ACC_W-1:0]};
			end
			OP_SWAP_LOW:
			begin
				acc_d = ret_q[ACC_W-1:0];
				ret_d = {ret_q[PTR_W-1:ACC_W], acc_q};
			end
			OP_SET_CARRY:
				carry_d = 1'b1;
			OP_CLEAR_CARRY:
				carry_d = 1'b0;
			OP_BRANCH_BIT_SET, OP_BRANCH_BIT_CLEAR:
			begin
				carry_d = opBit;
				if (opBit == (op == OP_BRANCH_BIT_SET))
					ip_d = opTarget;
			end
			default:
			begin
			end
		endcase
		// Debug writes land after instruction effects so the debugger wins
		if (dbgFlagWe)
		begin
			zero_d = dbgFlagWdata[FLAG_Z];
			carry_d = dbgFlagWdata[FLAG_C];
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Architectural registers

	// Accumulator
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			acc_q <= ACC_RESET;
		else if (illegalHit)
			acc_q <= ACC_RESET;
		else
			acc_q <= acc_d;
	end

	// Instruction pointer and return counter
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ip_q <= START_ADDR;
			ret_q <= START_ADDR;
		end
		else if (illegalHit)
		begin
			ip_q <= START_ADDR;
			ret_q <= START_ADDR;
		end
		else
		begin
			ip_q <= ip_d;
			ret_q <= ret_d;
		end
	end

	// Condition flags
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			zero_q <= ZERO_RESET;
			carry_q <= CARRY_RESET;
		end
		else if (illegalHit)
		begin
			zero_q <= ZERO_RESET;
			carry_q <= CARRY_RESET;
		end
		else
		begin
			zero_q <= zero_d;
			carry_q <= carry_d;
		end
	end

	assign accumulator = acc_q;
	assign instructionPointer = ip_q;
	assign shadowReturnCounter = ret_q;
	// Flags leave only on the debug port, never on the register bus
	assign dbgFlags = {zero_q, carry_q};

	//////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	logic awHeld_q, wHeld_q;
	logic [AXI_AW-1:0] awAddr_q;
	logic [7:0] wByte_q;
	logic wLane_q;
	logic doWrite;
	logic [AXI_AW-1:0] wIdx, rIdx;
	logic wMapped;

	// Address and data are taken in either order, one write in flight
	assign awready = !awHeld_q && !bvalid;
	assign wready = !wHeld_q && !bvalid;
	assign doWrite = awHeld_q && wHeld_q && !bvalid;
	assign wIdx = {2'b00, awAddr_q[AXI_AW-1:2]};
	assign wMapped = (wIdx == IDX_WINDOW) || (wIdx == IDX_INDEX)
		|| (wIdx == IDX_PAGE) || (wIdx == IDX_CORE_STATE);

	// Write channel capture
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wByte_q <= '0;
			wLane_q <= 1'b0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awHeld_q <= 1'b1;
				awAddr_q <= awaddr;
			end
			else if (doWrite)
				awHeld_q <= 1'b0;
			if (wvalid && wready)
			begin
				wHeld_q <= 1'b1;
				wByte_q <= wdata[7:0];
				wLane_q <= wstrb[0];
			end
			else if (doWrite)
				wHeld_q <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer with a decode error
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end
		else if (doWrite)
		begin
			bvalid <= 1'b1;
			bresp <= wMapped ? RESP_OKAY : RESP_DECERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	// Index and page registers; only byte lane zero carries data
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			index_q <= INDEX_RESET;
			page_q <= PAGE_RESET;
		end
		else if (illegalHit)
		begin
			index_q <= INDEX_RESET;
			page_q <= PAGE_RESET;
		end
		else if (doWrite && wLane_q)
		begin
			if (wIdx == IDX_INDEX)
				index_q <= wByte_q;
			if (wIdx == IDX_PAGE)
				page_q <= wByte_q;
		end
	end

	// Direct-page store behind the window; no reset, it is plain RAM
	always_ff @(posedge clock)
	begin
		if (doWrite && wLane_q && wIdx == IDX_WINDOW)
			dpRam[index_q] <= wByte_q;
	end

	// Read channel: data one cycle after the address is taken
	assign arready = !rvalid;
	assign rIdx = {2'b00, araddr[AXI_AW-1:2]};

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			case (rIdx)
				IDX_WINDOW:
					rdata <= {24'h000000, dpRam[index_q]};
				IDX_INDEX:
					rdata <= {24'h000000, index_q};
				IDX_PAGE:
					rdata <= {24'h000000, page_q};
				// Flags are deliberately left out of this view
				IDX_CORE_STATE:
					rdata <= {2'b00, ip_q, acc_q, 8'h00};
				default:
				begin
					rdata <= '0;
					rresp <= RESP_DECERR;
				end
			endcase
		end
		else if (rready)
			rvalid <= 1'b0;
	end

endmodule

// ---- ccrs_core_asserts.sv ----
// Assertion checker for the core register state block
module ccrs_core_asserts
	import ccrs_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic opValid,
	input wire logic [4:0] opCode,
	input wire logic [7:0] opOperand,
	input wire logic [13:0] opTarget,
	input wire logic fetchStrobe,
	input wire logic dbgFlagWe,
	input wire logic [1:0] dbgFlagWdata,
	input wire logic [1:0] dbgFlags,
	input wire logic [7:0] accumulator,
	input wire logic [13:0] instructionPointer,
	input wire logic [13:0] shadowReturnCounter,
	input wire logic xlatValid,
	input wire logic [13:0] xlatAddr,
	input wire logic [13:0] physAddr,
	input wire logic physValid,
	input wire logic bvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Debug writes win over flag updates, so flag checks skip them
	wire logic opGo = opValid && !dbgFlagWe;
	////////////////////////////////////////
	property p_ip_step;
		fetchStrobe && !opValid |=> instructionPointer == $past(instructionPointer) + 14'h1;
	endproperty
	a_ip_step: assert property (p_ip_step) else $error("pointer step");
	property p_jump;
		opValid && opCode == OP_JUMP |=> instructionPointer == $past(opTarget);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target");
	property p_call;
		opValid && opCode == OP_JUMP_SUB |=> shadowReturnCounter == $past(instructionPointer) + $past(fetchStrobe);
	endproperty
	a_call: assert property (p_call) else $error("call save");
	property p_ret;
		opValid && opCode == OP_RETURN |=> instructionPointer == $past(shadowReturnCounter);
	endproperty
	a_ret: assert property (p_ret) else $error("return");
	property p_add;
		opGo && opCode == OP_ADD |=> {dbgFlags[FLAG_C], accumulator} == {1'b0, $past(accumulator)} + $past(opOperand);
	endproperty
	a_add: assert property (p_add) else $error("add");
	property p_sub;
		opGo && opCode == OP_SUB |=> dbgFlags[FLAG_C] == ($past(opOperand) > $past(accumulator));
	endproperty
	a_sub: assert property (p_sub) else $error("borrow");
	property p_dbg;
		dbgFlagWe |=> dbgFlags == $past(dbgFlagWdata);
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug flags");
	property p_page;
		xlatValid && xlatAddr >= PAGE_WIN_LO && xlatAddr <= PAGE_WIN_HI |=> physValid && physAddr[5:0] == $past(xlatAddr[5:0]);
	endproperty
	a_page: assert property (p_page) else $error("paged address");
	c_ret: cover property (opValid && opCode == OP_RETURN);
	c_phys: cover property (physValid);
	c_write: cover property (bvalid);
endmodule
bind ccrs_core ccrs_core_asserts u_asserts (
	.clock(clock),
	.rst(rst),
	.opValid(opValid),
	.opCode(opCode),
	.opOperand(opOperand),
	.opTarget(opTarget),
	.fetchStrobe(fetchStrobe),
	.dbgFlagWe(dbgFlagWe),
	.dbgFlagWdata(dbgFlagWdata),
	.dbgFlags(dbgFlags),
	.accumulator(accumulator),
	.instructionPointer(instructionPointer),
	.shadowReturnCounter(shadowReturnCounter),
	.xlatValid(xlatValid),
	.xlatAddr(xlatAddr),
	.physAddr(physAddr),
	.physValid(physValid),
	.bvalid(bvalid)
);

// ---- ccrs_mem_model.sv ----
// Behavioural model of the memory answering translated addresses
module ccrs_mem_model
(
	input wire logic clock,
	input wire logic [13:0] physAddr,
	input wire logic physValid,
	output logic [7:0] memByte
);
	timeunit 1ns;
	timeprecision 1ns;
	// Byte follows the address; idle lines toggle so stale data never looks valid
	initial memByte = 8'h5a;
	always @(posedge clock)
		memByte <= physValid ? physAddr[7:0] ^ {2'h0, physAddr[13:8]} : ~memByte;
endmodule

// ---- cpu_core_register_state_test.sv ----
// Self-checking testbench for the core register state block
module cpu_core_register_state_test
	import ccrs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst = 1, opValid = 0, fetchStrobe = 0, opBit = 0, xlatValid = 0, dbgFlagWe = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [4:0] opCode = 0;
	logic [7:0] opOperand = 0, awaddr = 0, araddr = 0, accumulator, memByte;
	logic [13:0] opTarget = 0, xlatAddr = 0, physAddr, instructionPointer, shadowReturnCounter;
	logic [1:0] dbgFlagWdata = 0, dbgFlags, bresp, rresp, gotResp;
	logic [31:0] wdata = 0, rdata, got;
	logic [3:0] wstrb = 4'hf;
	logic physValid, coreResetReq, awready, wready, bvalid, arready, rvalid;
	int miscompares = 0, checkCount = 0, seed = 32'h4bd1, ma, mip, mret, mz, mc, mx, mp, pa;
	ccrs_op_t ops[18] = '{OP_ADD, OP_SUB, OP_CMP, OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_LOAD, OP_AND,
		OP_OR, OP_EOR, OP_INC, OP_DEC, OP_CLR, OP_STORE, OP_MOVE, OP_SET_CARRY, OP_CLEAR_CARRY};
	ccrs_core dut (
		.clock(clock),
		.rst(rst),
		.opValid(opValid),
		.opCode(opCode),
		.opOperand(opOperand),
		.opTarget(opTarget),
		.opBit(opBit),
		.fetchStrobe(fetchStrobe),
		.xlatValid(xlatValid),
		.xlatAddr(xlatAddr),
		.physAddr(physAddr),
		.physValid(physValid),
		.coreResetReq(coreResetReq),
		.accumulator(accumulator),
		.instructionPointer(instructionPointer),
		.shadowReturnCounter(shadowReturnCounter),
		.dbgFlagWe(dbgFlagWe),
		.dbgFlagWdata(dbgFlagWdata),
		.dbgFlags(dbgFlags),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready)
	);
	ccrs_mem_model mem (
		.clock(clock),
		.physAddr(physAddr),
		.physValid(physValid),
		.memByte(memByte)
	);
	// Free-running system clock
	initial forever #5 clock = ~clock;
	////////////////////////////////////////
	task closeOut;
		$display("Counts: %0d checks, %0d miscompares", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(string n, logic [31:0] s, logic [31:0] e);
		checkCount++;
		if (s !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task chk_state;
		chk("acc", accumulator, ma);
		chk("ip", instructionPointer, mip);
		chk("ret", shadowReturnCounter, mret);
		chk("flags", dbgFlags, mz * 2 + mc);
	endtask
	task mreset;
		ma = 0;
		mip = 'h3ffd;
		mret = 'h3ffd;
		mz = 0;
		mc = 0;
		mx = 0;
		mp = 0;
	endtask
	// One operation; the model keeps carry in bit 8 of the 9-bit result
	task op(logic [4:0] c, int m, int t, logic b, logic f);
		int n, w;
		n = -1;
		@(posedge clock);
		opValid <= c != OP_NONE;
		opCode <= c;
		opOperand <= m[7:0];
		opTarget <= t[13:0];
		opBit <= b;
		fetchStrobe <= f;
		@(posedge clock);
		opValid <= 0;
		fetchStrobe <= 0;
		case (c)
			OP_ADD: n = ma + m;
			OP_SUB, OP_CMP: n = (m > ma ? 256 : 0) | ((ma - m) & 255);
			OP_LSL: n = ma << 1;
			OP_LSR: n = ((ma & 1) << 8) | (ma >> 1);
			OP_ROL: n = (ma << 1) | mc;
			OP_ROR: n = ((ma & 1) << 8) | (mc << 7) | (ma >> 1);
			OP_LOAD, OP_MOVE: n = (mc << 8) | m;
			OP_STORE: n = (mc << 8) | ma;
			OP_AND: n = (mc << 8) | (ma & m);
			OP_OR: n = (mc << 8) | (ma | m);
			OP_EOR: n = (mc << 8) | (ma ^ m);
			OP_INC: n = (mc << 8) | ((ma + 1) & 255);
			OP_DEC: n = (mc << 8) | ((ma + 255) & 255);
			OP_CLR: n = mc << 8;
			OP_SET_CARRY: mc = 1;
			OP_CLEAR_CARRY: mc = 0;
			OP_JUMP, OP_BRANCH: mip = t;
			OP_JUMP_SUB:
			begin
				mret = (mip + f) & 'h3fff;
				mip = t;
			end
			OP_RETURN: mip = mret;
			OP_SWAP_LOW:
			begin
				w = ma;
				ma = mret & 255;
				mret = (mret & 'h3f00) | w;
			end
			OP_SWAP_HIGH:
			begin
				w = ma;
				ma = mret >> 8;
				mret = ((w & 63) << 8) | (mret & 255);
			end
			OP_BRANCH_BIT_SET, OP_BRANCH_BIT_CLEAR:
			begin
				mc = b;
				if (c == OP_BRANCH_BIT_SET ? b : !b)
					mip = t;
			end
			OP_NONE: mip = (mip + f) & 'h3fff;
			default: mreset();
		endcase
		if (n >= 0)
		begin
			mc = (n >> 8) & 1;
			mz = (n & 255) == 0;
			if (c != OP_CMP && c != OP_MOVE) ma = n & 255;
		end
		#1;
		chk_state();
	endtask
	// Bus write: address and data offered together, each released when taken
	task wr(logic [7:0] a, int d);
		logic ah, wh;
		ah = 0;
		wh = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(ah && wh))
		begin
			@(posedge clock);
			if (!ah && awready) awvalid <= 0;
			if (!wh && wready) wvalid <= 0;
			ah = ah | awready;
			wh = wh | wready;
		end
		do @(posedge clock); while (!bvalid);
		bready <= 0;
		gotResp = bresp;
	endtask
	task rd(logic [7:0] a);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge clock); while (!arready);
		arvalid <= 0;
		do @(posedge clock); while (!rvalid);
		rready <= 0;
		got = rdata;
		gotResp = rresp;
	endtask
	task xl(int a);
		@(posedge clock);
		xlatValid <= 1;
		xlatAddr <= a[13:0];
		@(posedge clock);
		xlatValid <= 0;
		#1;
	endtask
	////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clock);
		rst <= 0;
		mreset();
		#1;
		chk_state();
		$display("Test reset done");
		repeat (300) op(ops[$unsigned($random(seed)) % 18], $random(seed) & 255, 0, 0, 0);
		$display("Test alu done");
		repeat (4) op(OP_NONE, 0, 0, 0, 1);
		op(OP_JUMP, 0, 'h0123, 0, 0);
		op(OP_JUMP_SUB, 0, 'h0200, 0, 1);
		op(OP_SWAP_LOW, 0, 0, 0, 0);
		op(OP_RETURN, 0, 0, 0, 0);
		op(OP_SWAP_HIGH, 0, 0, 0, 0);
		op(OP_BRANCH, 0, 'h0280, 0, 0);
		op(OP_BRANCH_BIT_SET, 0, 'h0321, 1, 0);
		op(OP_BRANCH_BIT_SET, 0, 'h0400, 0, 0);
		op(OP_BRANCH_BIT_CLEAR, 0, 'h0155, 0, 0);
		op(OP_BRANCH_BIT_CLEAR, 0, 'h0266, 1, 0);
		@(posedge clock);
		dbgFlagWe <= 1;
		dbgFlagWdata <= 2'h2;
		@(posedge clock);
		dbgFlagWe <= 0;
		mz = 1;
		mc = 0;
		#1;
		chk_state();
		$display("Test flow done");
		mx = $random(seed) & 255;
		mp = $random(seed) & 255;
		wr(IDX_INDEX << 2, mx);
		chk("index resp", gotResp, 0);
		wr(IDX_PAGE << 2, mp);
		wr(IDX_WINDOW << 2, mp ^ 255);
		rd(IDX_WINDOW << 2);
		chk("window data", got, mp ^ 255);
		wr(8'h40, 0);
		chk("unmapped resp", gotResp, 3);
		rd(IDX_INDEX << 2);
		chk("index", got, mx);
		rd(IDX_PAGE << 2);
		chk("page", got, mp);
		rd(8'h40);
		chk("unmapped", gotResp, 3);
		rd(IDX_CORE_STATE << 2);
		chk("core", got, (mip << 16) | (ma << 8));
		xl(WINDOW_ADDR);
		chk("window", physAddr, mx);
		chk("phys valid", physValid, 1);
		pa = ((mp << 6) | 5) & 'h3fff;
		xl('h00c5);
		chk("paged", physAddr, pa);
		@(posedge clock);
		#1;
		op(OP_LOAD, memByte, 0, 0, 0);
		chk("fetched", accumulator, (pa & 255) ^ (pa >> 8));
		$display("Test bus done");
		op(5'd27, 0, 0, 0, 0);
		chk("reset req", coreResetReq, 1);
		rd(IDX_INDEX << 2);
		chk("index", got, mx);
		$display("Test illegal done");
		// Reset again in mid-run, with the state dirtied first
		op(OP_LOAD, 'h5a, 0, 0, 0);
		@(posedge clock);
		rst <= 1;
		repeat (3) @(posedge clock);
		rst <= 0;
		mreset();
		#1;
		chk_state();
		$display("Test second reset done");
		closeOut();
	end
	// Watchdog cuts a hang short
	initial
	begin
		#100000;
		miscompares++;
		closeOut();
	end
endmodule
